/* nsr_pkg.sv */
// nsr_pkg.sv: constants for the node slot routing block
package nsr_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_CONTROL    = 8'h00;
	localparam logic [7:0] ADDR_DN_PASS    = 8'h04;
	localparam logic [7:0] ADDR_UP_PASS    = 8'h08;
	localparam logic [7:0] ADDR_BCAST_DN   = 8'h0C;
	localparam logic [7:0] ADDR_LOCAL_DN   = 8'h10;
	localparam logic [7:0] ADDR_LOCAL_UP   = 8'h14;
	localparam logic [7:0] ADDR_DN_MASK0   = 8'h18;
	localparam logic [7:0] ADDR_UP_MASK0   = 8'h28;
	localparam logic [7:0] ADDR_DN_OFFSET  = 8'h38;
	localparam logic [7:0] ADDR_UP_OFFSET  = 8'h3C;
	localparam logic [7:0] ADDR_TX_SKIP    = 8'h40;
	localparam logic [7:0] ADDR_STATUS     = 8'h44;
	localparam logic [7:0] ADDR_EXTENT     = 8'h48;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int         CTRL_APPLY_BIT  = 0;
	localparam int         CTRL_MAIN_BIT   = 1;
	localparam int         LDN_MASKEN_BIT  = 7;
	localparam int         SLOT_W          = 6;
	localparam int         MASK_REGS       = 4;
	localparam logic [7:0] RST_COUNT       = 8'h00;
	localparam logic [7:0] RST_MASK        = 8'h00;
	localparam int         MAX_SLOTS       = 32;
	localparam int         ADDR_W          = 8;
	localparam int         DATA_W          = 8;

	// ****************************************
	// per-slot routing actions
	// ****************************************
	typedef enum logic [1:0] {
		NSR_IDLE = 2'b00,
		NSR_DOWN = 2'b01,
		NSR_UP   = 2'b10
	} nsr_phase_e;

endpackage : nsr_pkg

/* nsr_ext.sv */
// nsr_ext.sv: highest-set-bit extent of a 32-bit consume mask
module nsr_ext (
	// mask in
	input  wire logic [31:0] mask,
	// extent out
	output logic      [6:0]  extent
);

	// ****************************************
	// extent = index of highest set bit + 1
	// ****************************************
	always_comb begin
		extent = 7'h00;
		for (int i = 0; i < 32; i++) begin
			if (mask[i]) begin
				extent = 7'(i + 1);
			end
		end
	end

endmodule // nsr_ext

/* nsr_route.sv */
// nsr_route.sv: slot routing for one bus transceiver node
// Function
// - old slot settings stay active until the apply bit is written.
// - settings rewritable at run time; mapping may glitch briefly after apply.
// - slot counts cover audio channels only, never tunnelled control slots.
// - main node sends downstream slots 0..pass-1 from receive buffer in order.
// - main node captures upstream slots 0..count-1 into transmit buffer.
// - main node captures every upstream slot within count, no per-slot mask.
// - main node ignores broadcast, local counts, masks and contribution offsets.
// - subordinate forwards downstream slots 0..pass-1 unchanged.
// - subordinate consumes and forwards broadcast count slots downstream.
// - downstream consume mask, one bit per slot, four registers, 32 slots.
// - contributed slots read receive buffer from location zero plus offset.
// - mask enable 0: local count consumed, not forwarded.
// - mask enable 0: no contribution, consume mask ignored.
// - mask enable 1: local slots contributed after pass slots; mask selects capture.
// - mask mode receives max(pass, mask extent), sends pass plus local.
// - mask enable 1: broadcast count ignored.
// - consumed downstream packed from location 0; upstream follows directly.
//
// The address-and-strobe port and the address map were left to the implementer.
module nsr_route #(
	parameter int SLOT_W = nsr_pkg::SLOT_W,
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic                  clk_en,
	// register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	// slot timing from the superframe engine
	input  wire logic                  slot_valid,
	input  wire logic                  slot_up,
	input  wire logic [SLOT_W-1:0]     slot_idx,
	input  wire logic                  frame_start,
	// incoming slot data (upstream-side for down, downstream-side for up)
	input  wire logic [DATA_W-1:0]     slot_rx_data,
	// receive frame buffer read port
	output logic      [SLOT_W-1:0]     rxbuf_addr,
	input  wire logic [DATA_W-1:0]     rxbuf_data,
	// transmit frame buffer write port
	output logic                       txbuf_we,
	output logic      [SLOT_W-1:0]     txbuf_addr,
	output logic      [DATA_W-1:0]     txbuf_data,
	// outgoing slot data
	output logic                       slot_tx_en,
	output logic      [DATA_W-1:0]     slot_tx_data,
	// applied counts for the framing logic
	output logic      [7:0]            down_rx_slots,
	output logic      [7:0]            down_tx_slots,
	output logic      [7:0]            up_rx_slots,
	output logic      [7:0]            serial_tx_channel_skip
);

	// ****************************************
	// shadow and active settings
	// ****************************************
	logic [7:0]  shadow_r   [0:10];
	logic [7:0]  shadow_nxt [0:10];
	logic [7:0]  active_r   [0:10];
	logic [7:0]  active_nxt [0:10];
	logic [31:0] dn_mask_shadow_r;
	logic [31:0] dn_mask_shadow_nxt;
	logic [31:0] up_mask_shadow_r;
	logic [31:0] up_mask_shadow_nxt;
	logic [31:0] dn_mask_r;
	logic [31:0] dn_mask_nxt;
	logic [31:0] up_mask_r;
	logic [31:0] up_mask_nxt;
	logic        is_main_r;
	logic        is_main_nxt;
	logic        applied_r;
	logic        applied_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;

	// index into the shadow array
	localparam int S_DN = 0;
	localparam int S_UP = 1;
	localparam int S_BC = 2;
	localparam int S_LD = 3;
	localparam int S_LU = 4;
	localparam int S_DO = 5;
	localparam int S_UO = 6;
	localparam int S_TS = 7;

	function automatic logic [7:0] mask_byte(input logic [31:0] m, input logic [1:0] b);
		mask_byte = m[8*b +: 8];
	endfunction

	function automatic logic [31:0] put_byte(input logic [31:0] m, input logic [1:0] b,
		input logic [7:0] v);
		logic [31:0] r;
		r = m;
		r[8*b +: 8] = v;
		put_byte = r;
	endfunction

	logic [6:0] dn_extent;

	nsr_ext u_ext_dn (
		.mask   (dn_mask_r),
		.extent (dn_extent)
	);

	// ****************************************
	// register access
	// ****************************************
	always_comb begin
		shadow_nxt         = shadow_r;
		active_nxt         = active_r;
		dn_mask_shadow_nxt = dn_mask_shadow_r;
		up_mask_shadow_nxt = up_mask_shadow_r;
		dn_mask_nxt        = dn_mask_r;
		up_mask_nxt        = up_mask_r;
		is_main_nxt        = is_main_r;
		applied_nxt        = applied_r;
		rdata_nxt          = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				nsr_pkg::ADDR_CONTROL: begin
					is_main_nxt = reg_wdata[nsr_pkg::CTRL_MAIN_BIT];
					if (reg_wdata[nsr_pkg::CTRL_APPLY_BIT]) begin
						// takes the written shadow set at once
						active_nxt  = shadow_r;
						dn_mask_nxt = dn_mask_shadow_r;
						up_mask_nxt = up_mask_shadow_r;
						applied_nxt = 1'b1;
					end
				end
				nsr_pkg::ADDR_DN_PASS:   shadow_nxt[S_DN] = reg_wdata;
				nsr_pkg::ADDR_UP_PASS:   shadow_nxt[S_UP] = reg_wdata;
				nsr_pkg::ADDR_BCAST_DN:  shadow_nxt[S_BC] = reg_wdata;
				nsr_pkg::ADDR_LOCAL_DN:  shadow_nxt[S_LD] = reg_wdata;
				nsr_pkg::ADDR_LOCAL_UP:  shadow_nxt[S_LU] = reg_wdata;
				nsr_pkg::ADDR_DN_OFFSET: shadow_nxt[S_DO] = reg_wdata;
				nsr_pkg::ADDR_UP_OFFSET: shadow_nxt[S_UO] = reg_wdata;
				nsr_pkg::ADDR_TX_SKIP:   shadow_nxt[S_TS] = reg_wdata;
				default: begin
					if (reg_addr[7:4] == 4'h1 || reg_addr[7:4] == 4'h2) begin
						if (reg_addr >= nsr_pkg::ADDR_DN_MASK0
							&& reg_addr < nsr_pkg::ADDR_UP_MASK0) begin
							dn_mask_shadow_nxt = put_byte(dn_mask_shadow_r,
								2'(reg_addr[3:2] - 2'h2), reg_wdata);
						end
					end
					if (reg_addr >= nsr_pkg::ADDR_UP_MASK0
						&& reg_addr < nsr_pkg::ADDR_DN_OFFSET) begin
						up_mask_shadow_nxt = put_byte(up_mask_shadow_r,
							2'(reg_addr[3:2] - 2'h2), reg_wdata);
					end
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				nsr_pkg::ADDR_CONTROL:   rdata_nxt = {6'h00, is_main_r, 1'b0};
				nsr_pkg::ADDR_DN_PASS:   rdata_nxt = shadow_r[S_DN];
				nsr_pkg::ADDR_UP_PASS:   rdata_nxt = shadow_r[S_UP];
				nsr_pkg::ADDR_BCAST_DN:  rdata_nxt = shadow_r[S_BC];
				nsr_pkg::ADDR_LOCAL_DN:  rdata_nxt = shadow_r[S_LD];
				nsr_pkg::ADDR_LOCAL_UP:  rdata_nxt = shadow_r[S_LU];
				nsr_pkg::ADDR_DN_OFFSET: rdata_nxt = shadow_r[S_DO];
				nsr_pkg::ADDR_UP_OFFSET: rdata_nxt = shadow_r[S_UO];
				nsr_pkg::ADDR_TX_SKIP:   rdata_nxt = shadow_r[S_TS];
				nsr_pkg::ADDR_STATUS:    rdata_nxt = {7'h00, applied_r};
				nsr_pkg::ADDR_EXTENT:    rdata_nxt = {1'b0, dn_extent};
				default: begin
					if (reg_addr >= nsr_pkg::ADDR_DN_MASK0
						&& reg_addr < nsr_pkg::ADDR_UP_MASK0) begin
						rdata_nxt = mask_byte(dn_mask_shadow_r, 2'(reg_addr[3:2] - 2'h2));
					end else if (reg_addr >= nsr_pkg::ADDR_UP_MASK0
						&& reg_addr < nsr_pkg::ADDR_DN_OFFSET) begin
						rdata_nxt = mask_byte(up_mask_shadow_r, 2'(reg_addr[3:2] - 2'h2));
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 11; i++) begin
				shadow_r[i] <= nsr_pkg::RST_COUNT;
				active_r[i] <= nsr_pkg::RST_COUNT;
			end
			dn_mask_shadow_r <= 32'h0000_0000;
			up_mask_shadow_r <= 32'h0000_0000;
			dn_mask_r        <= 32'h0000_0000;
			up_mask_r        <= 32'h0000_0000;
			is_main_r        <= 1'b0;
			applied_r        <= 1'b0;
			rdata_r          <= 8'h00;
		end else if (clk_en) begin
			shadow_r         <= shadow_nxt;
			active_r         <= active_nxt;
			dn_mask_shadow_r <= dn_mask_shadow_nxt;
			up_mask_shadow_r <= up_mask_shadow_nxt;
			dn_mask_r        <= dn_mask_nxt;
			up_mask_r        <= up_mask_nxt;
			is_main_r        <= is_main_nxt;
			applied_r        <= applied_nxt;
			rdata_r          <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// ****************************************
	// derived slot counts
	// ****************************************
	logic       mask_mode;
	logic [7:0] dn_pass;
	logic [7:0] local_dn;
	logic [7:0] bcast;
	logic [7:0] dn_rx_c;
	logic [7:0] dn_tx_c;
	logic [7:0] ext8;

	always_comb begin
		// counts are audio-only; tunnel slots live elsewhere
		dn_pass   = active_r[S_DN];
		mask_mode = active_r[S_LD][nsr_pkg::LDN_MASKEN_BIT];
		local_dn  = {1'b0, active_r[S_LD][6:0]};
		bcast     = mask_mode ? 8'h00 : active_r[S_BC];
		ext8      = {1'b0, dn_extent};
		if (is_main_r) begin
			dn_rx_c = 8'h00;
			dn_tx_c = dn_pass;
		end else if (mask_mode) begin
			dn_rx_c = (dn_pass > ext8) ? dn_pass : ext8;
			dn_tx_c = 8'(dn_pass + local_dn);
		end else begin
			dn_rx_c = 8'(bcast + dn_pass + local_dn);
			dn_tx_c = 8'(bcast + dn_pass);
		end
	end

	assign down_rx_slots          = dn_rx_c;
	assign down_tx_slots          = dn_tx_c;
	assign up_rx_slots            = active_r[S_UP];
	assign serial_tx_channel_skip = is_main_r ? active_r[S_TS] : 8'h00;

	// ****************************************
	// per-slot routing
	// ****************************************
	logic [SLOT_W-1:0] pack_r;
	logic [SLOT_W-1:0] pack_nxt;
	logic              we_r;
	logic              we_nxt;
	logic [SLOT_W-1:0] waddr_r;
	logic [SLOT_W-1:0] waddr_nxt;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] wdata_nxt;
	logic              txen_r;
	logic              txen_nxt;
	logic [DATA_W-1:0] txd_r;
	logic [DATA_W-1:0] txd_nxt;
	logic [SLOT_W-1:0] rx_addr_c;
	logic [7:0]        idx8;
	logic              take;

	always_comb begin
		pack_nxt   = pack_r;
		we_nxt     = 1'b0;
		waddr_nxt  = waddr_r;
		wdata_nxt  = wdata_r;
		txen_nxt   = 1'b0;
		txd_nxt    = txd_r;
		rx_addr_c  = '0;
		idx8       = 8'(slot_idx);
		take       = 1'b0;
		if (frame_start) begin
			pack_nxt   = '0;
		end else if (slot_valid && !slot_up) begin
			if (is_main_r) begin
				if (idx8 < dn_tx_c) begin
					rx_addr_c = slot_idx;
					txen_nxt  = 1'b1;
					txd_nxt   = rxbuf_data;
				end
			end else if (mask_mode) begin
				if (idx8 < dn_pass) begin
					txen_nxt = 1'b1;
					txd_nxt  = slot_rx_data;
				end else if (idx8 < dn_tx_c) begin
					rx_addr_c  = SLOT_W'(active_r[S_DO] + (idx8 - dn_pass));
					txen_nxt   = 1'b1;
					txd_nxt    = rxbuf_data;
				end
				take = (idx8 < 8'(nsr_pkg::MAX_SLOTS)) && dn_mask_r[slot_idx[4:0]];
			end else begin
				// mask ignored here
				if (idx8 < dn_tx_c) begin
					txen_nxt = 1'b1;
					txd_nxt  = slot_rx_data;
				end
				take = (idx8 < bcast)
					|| (idx8 >= dn_tx_c && idx8 < dn_rx_c);
			end
		end else if (slot_valid && slot_up && idx8 < active_r[S_UP]) begin
			// main: every slot within count, no masking
			take = is_main_r || up_mask_r[slot_idx[4:0]];
		end
		if (take) begin
			we_nxt    = 1'b1;
			waddr_nxt = pack_r;
			wdata_nxt = slot_rx_data;
			pack_nxt  = SLOT_W'(pack_r + 1'b1);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pack_r   <= '0;
			we_r     <= 1'b0;
			waddr_r  <= '0;
			wdata_r  <= '0;
			txen_r   <= 1'b0;
			txd_r    <= '0;
		end else if (clk_en) begin
			pack_r   <= pack_nxt;
			we_r     <= we_nxt;
			waddr_r  <= waddr_nxt;
			wdata_r  <= wdata_nxt;
			txen_r   <= txen_nxt;
			txd_r    <= txd_nxt;
		end
	end

	// receive buffer read is combinational: data returns same cycle
	assign rxbuf_addr   = rx_addr_c;
	assign txbuf_we     = we_r;
	assign txbuf_addr   = waddr_r;
	assign txbuf_data   = wdata_r;
	assign slot_tx_en   = txen_r;
	assign slot_tx_data = txd_r;

endmodule // nsr_route

/* nsr_route_chk.sv */
// nsr_route_chk.sv: port checker for the node slot routing block
// ****************************************
// slot routing checker
// ****************************************
module nsr_route_chk #(
	parameter int SLOT_W = 6
) (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              nrst,
	input wire logic              clk_en,
	// register port
	input wire logic [7:0]        reg_addr,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	// slot path
	input wire logic              slot_valid,
	input wire logic              slot_up,
	input wire logic [SLOT_W-1:0] slot_idx,
	input wire logic              txbuf_we,
	input wire logic [SLOT_W-1:0] txbuf_addr,
	input wire logic              slot_tx_en,
	// applied counts
	input wire logic [7:0]        down_tx_slots,
	input wire logic [7:0]        down_rx_slots,
	input wire logic [7:0]        up_rx_slots
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	property p_tx_follow;
		slot_tx_en && $past(clk_en) |-> $past(slot_valid);
	endproperty
	property p_we_follow;
		txbuf_we && $past(clk_en) |-> $past(slot_valid);
	endproperty
	property p_tx_window;
		slot_tx_en && $past(clk_en) && !$past(slot_up) |-> $past(slot_idx) < $past(down_tx_slots);
	endproperty
	property p_we_down;
		txbuf_we && $past(clk_en) && !$past(slot_up) |-> $past(slot_idx) < $past(down_rx_slots);
	endproperty
	property p_we_up;
		txbuf_we && $past(clk_en) && $past(slot_up) |-> $past(slot_idx) < $past(up_rx_slots);
	endproperty
	// consecutive captures never leave a hole in the buffer
	property p_pack;
		txbuf_we && $past(txbuf_we) && $past(clk_en) |-> txbuf_addr == $past(txbuf_addr) + 1'b1;
	endproperty
	property p_dtx_apply;
		$changed(down_tx_slots) |-> $past(reg_wr) || $past(reg_wr, 2);
	endproperty
	property p_urx_apply;
		$changed(up_rx_slots) |-> $past(reg_wr) || $past(reg_wr, 2);
	endproperty
	property p_apply_reads_zero;
		$past(reg_rd && clk_en && reg_addr == 8'h00) |-> reg_rdata[0] == 1'b0;
	endproperty

	a_tx_follow: assert property (p_tx_follow) else $error("slot output without a slot");
	a_we_follow: assert property (p_we_follow) else $error("capture without a slot");
	a_tx_window: assert property (p_tx_window) else $error("slot sent past count");
	a_we_down: assert property (p_we_down) else $error("down capture past extent");
	a_we_up: assert property (p_we_up) else $error("up capture past count");
	a_pack: assert property (p_pack) else $error("capture location skipped");
	a_dtx_apply: assert property (p_dtx_apply) else $error("down count moved alone");
	a_urx_apply: assert property (p_urx_apply) else $error("up count moved alone");
	a_apply_reads_zero: assert property (p_apply_reads_zero) else $error("apply bit read 1");

	c_tx: cover property (slot_tx_en);
	c_up_cap: cover property (txbuf_we && $past(slot_up));
	c_apply: cover property ($changed(down_tx_slots));
endmodule // nsr_route_chk

bind nsr_route nsr_route_chk #(.SLOT_W(SLOT_W)) u_chk (.clk_sys, .nrst, .clk_en, .reg_addr,
	.reg_wr, .reg_rd, .reg_rdata, .slot_valid, .slot_up, .slot_idx, .txbuf_we, .txbuf_addr,
	.slot_tx_en, .down_tx_slots, .down_rx_slots, .up_rx_slots);

/* nsr_nbr.sv */
// nsr_nbr.sv: neighbour node and local receive buffer model
// ****************************************
// neighbour model
// ****************************************
module nsr_nbr (
	// slot timing
	input wire logic        clk_sys,
	input wire logic        slot_valid,
	input wire logic        slot_up,
	input wire logic [5:0]  slot_idx,
	// buffer read
	input wire logic [5:0]  rxbuf_addr,
	// data out
	output logic     [31:0] slot_rx_data,
	output logic     [31:0] rxbuf_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] last_r = 32'h00000000;
	always @(posedge clk_sys) if (slot_valid) last_r <= slot_rx_data;
	// idle bus shows the inverse so stale data never looks valid
	assign slot_rx_data = slot_valid ? {slot_up ? 8'h3C : 8'hC3, 18'h00000, slot_idx} : ~last_r;
	assign rxbuf_data = {8'h5A, 18'h00000, rxbuf_addr};
endmodule // nsr_nbr

/* tb_nsr_route.sv */
// tb_nsr_route.sv: self-checking bench for the node slot routing block
module tb_nsr_route;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// signals and instances
	// ****************************************
	logic        clk_sys = 0, nrst = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
	logic        slot_valid = 0, slot_up = 0, frame_start = 0, txbuf_we, slot_tx_en;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [7:0]  down_rx_slots, down_tx_slots, up_rx_slots, serial_tx_channel_skip;
	logic [5:0]  slot_idx = 0, rxbuf_addr, txbuf_addr;
	logic [31:0] slot_rx_data, rxbuf_data, txbuf_data, slot_tx_data;
	int          fail_count = 0, num_checks = 0;
	typedef struct {logic main; logic [7:0] pass, up, bc, ldn, off, drx, dtx, nd, nu;
		logic [31:0] mask;} nsr_row_s;
	// main, pass, up, bc, local, offset, rx, tx, down slots, up slots, mask
	nsr_row_s rows [5] = '{
		'{1'b1, 8'h05, 8'h03, 8'h02, 8'h03, 8'h00, 8'h00, 8'h05, 8'h06, 8'h04, 32'hFF},
		'{1'b0, 8'h04, 8'h00, 8'h02, 8'h03, 8'h00, 8'h09, 8'h06, 8'h09, 8'h00, 32'h30},
		'{1'b0, 8'h04, 8'h00, 8'h02, 8'h84, 8'h02, 8'h06, 8'h08, 8'h08, 8'h00, 32'h30},
		'{1'b0, 8'h06, 8'h00, 8'h00, 8'h82, 8'h00, 8'h06, 8'h08, 8'h08, 8'h00, 32'h00},
		'{1'b0, 8'h06, 8'h00, 8'h00, 8'h84, 8'h00, 8'h0A, 8'h0A, 8'h0A, 8'h00, 32'h3CC}};
	always #5 clk_sys = ~clk_sys;
	nsr_route dut (.clk_sys, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.slot_valid, .slot_up, .slot_idx, .frame_start, .slot_rx_data, .rxbuf_addr, .rxbuf_data,
		.txbuf_we, .txbuf_addr, .txbuf_data, .slot_tx_en, .slot_tx_data, .down_rx_slots,
		.down_tx_slots, .up_rx_slots, .serial_tx_channel_skip);
	nsr_nbr nbr (.clk_sys, .slot_valid, .slot_up, .slot_idx, .rxbuf_addr, .slot_rx_data,
		.rxbuf_data);
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic cfg(input nsr_row_s r);
		wr(8'h04, r.pass); wr(8'h08, r.up); wr(8'h0C, r.bc); wr(8'h10, r.ldn); wr(8'h38, r.off);
		for (int i = 0; i < 4; i++) wr(8'(8'h18 + 4 * i), r.mask[8 * i +: 8]);
		wr(8'h00, {6'h00, r.main, 1'b1});
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// one frame: down slots then up slots, outputs checked one cycle late
	task automatic run(input nsr_row_s r);
		logic [5:0] p; logic [7:0] j; logic u, c, t; logic [31:0] d, f; int k;
		p = 6'h00;
		@(posedge clk_sys); frame_start <= 1'b1;
		@(posedge clk_sys); frame_start <= 1'b0;
		for (k = 0; k <= r.nd + r.nu; k++) begin
			@(posedge clk_sys);
			slot_valid <= (k < r.nd + r.nu);
			slot_up <= (k >= r.nd);
			slot_idx <= 6'((k >= r.nd) ? k - r.nd : k);
			#1;
			if (k > 0) begin
				u = (k - 1 >= r.nd);
				j = 8'(u ? k - 1 - r.nd : k - 1);
				f = {u ? 8'h3C : 8'hC3, 18'h00000, j[5:0]};
				d = f;
				if (u) begin c = r.main && (j < r.up); t = 1'b0; end
				else if (r.main) begin c = 1'b0; t = (j < r.pass); d = {8'h5A, 18'h00000, j[5:0]}; end
				else if (!r.ldn[7]) begin
					t = (j < r.bc + r.pass);
					c = (j < r.bc) || (j >= r.bc + r.pass && j < r.bc + r.pass + r.ldn);
				end else begin
					t = (j < r.pass + r.ldn[6:0]);
					c = r.mask[j[4:0]];
					if (j >= r.pass) d = {8'h5A, 18'h00000, 6'(r.off + j - r.pass)};
				end
				chk(slot_tx_en, t);
				if (t) chk(slot_tx_data, d);
				chk(txbuf_we, c);
				if (c) begin
					chk(txbuf_addr, p);
					chk(txbuf_data, f);
					p = p + 6'h01;
				end
			end
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		#500000;
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		#1 chk(down_tx_slots, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h44, 8'h00);
		for (int i = 0; i < 5; i++) begin
			cfg(rows[i]);
			if (!rows[i].main) chk(down_rx_slots, rows[i].drx);
			chk(down_tx_slots, rows[i].dtx);
			if (rows[i].main) chk(up_rx_slots, rows[i].up);
			run(rows[i]);
			$display("row %0d done", i);
		end
		wr(8'h04, 8'h09);
		wr(8'h40, 8'h0A);
		// main bit acts at once, the rest waits for apply
		wr(8'h00, 8'h02);
		#1 chk(down_tx_slots, 8'h06);
		chk(serial_tx_channel_skip, 8'h00);
		rd(8'h04, 8'h09);
		rd(8'h00, 8'h02);
		rd(8'h1C, 8'h03);
		wr(8'h2C, 8'h5A);
		rd(8'h2C, 8'h5A);
		wr(8'h00, 8'h01);
		repeat (2) @(posedge clk_sys);
		#1 chk(down_tx_slots, 8'h0D);
		chk(down_rx_slots, 8'h0A);
		chk(serial_tx_channel_skip, 8'h00);
		rd(8'h48, 8'h0A);
		rd(8'h44, 8'h01);
		wr(8'h00, 8'h03);
		#1 chk(serial_tx_channel_skip, 8'h0A);
		chk(down_rx_slots, 8'h00);
		chk(down_tx_slots, 8'h09);
		wr(8'h4C, 8'hFF);
		rd(8'h4C, 8'h00);
		$display("apply test done");
		// a write while the enable is low must not land
		@(posedge clk_sys); clk_en <= 1'b0;
		wr(8'h04, 8'h07);
		clk_en <= 1'b1;
		rd(8'h04, 8'h09);
		$display("enable test done");
		@(posedge clk_sys); nrst <= 1'b0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		#1 chk(down_tx_slots, 8'h00);
		rd(8'h04, 8'h00);
		$display("reset test done");
		give_verdict;
	end
endmodule // tb_nsr_route
